// File: uadm_fifo.sv
`default_nettype none

module uadm_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic       clock,
	input  wire logic       arst_n,
	uadm_stream_if.consumer inPort,
	uadm_stream_if.producer outPort
);
	import uadm_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               rd;
		logic [PW-1:0]               wr;
		logic [PW:0]                 count;
	} uadm_fifo_state_type;

	uadm_fifo_state_type cur;
	uadm_fifo_state_type next_cur;
	logic                doPush;
	logic                doPop;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	assign inPort.ready  = (cur.count != (PW + 1)'(DEPTH));
	assign outPort.valid = (cur.count != '0);
	assign outPort.data  = cur.mem[cur.rd];
	assign doPush        = inPort.valid && inPort.ready;
	assign doPop         = outPort.valid && outPort.ready;

	always_comb begin
		next_cur = cur;
		if (doPush) begin
			next_cur.mem[cur.wr] = inPort.data;
			next_cur.wr          = bump(cur.wr);
		end
		if (doPop) begin
			next_cur.rd = bump(cur.rd);
		end
		if (doPush && !doPop) begin
			next_cur.count = cur.count + 1'b1;
		end else if (doPop && !doPush) begin
			next_cur.count = cur.count - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end
endmodule // uadm_fifo

`default_nettype wire

// File: uadm_map.svh
`ifndef UADM_MAP_SVH
`define UADM_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define UADM_OFS_RX_CHAR    6'h00
`define UADM_OFS_TX_CHAR    6'h04
`define UADM_OFS_BAUD       6'h08
`define UADM_OFS_ADMD       6'h0C
`define UADM_OFS_CTRL       6'h10
`define UADM_OFS_STAT       6'h14

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define UADM_CTRL_PARITY_DATA_SELECT_LSB 0
`define UADM_CTRL_HIGH_SPEED_BIT_TIMING      2
`define UADM_CTRL_ADDRESS_DETECT_ENABLE     3
`define UADM_CTRL_RXEN      4
`define UADM_CTRL_TXEN      5
`define UADM_CTRL_W         6

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define UADM_STAT_RXDA      0
`define UADM_STAT_OERR      1
`define UADM_STAT_FERR      2
`define UADM_STAT_PERR      3
`define UADM_STAT_RIDLE     4
`define UADM_STAT_TRMT      5
`define UADM_STAT_TXBF      6
`define UADM_STAT_MATCHED   7

// ----------------------------------------------------------------
// Field layouts and encodings
// ----------------------------------------------------------------
`define UADM_MASK_LSB       8
`define UADM_ADDR_LSB       0
`define UADM_PARITY_DATA_SELECT_8N       2'h0
`define UADM_PARITY_DATA_SELECT_8E       2'h1
`define UADM_PARITY_DATA_SELECT_8O       2'h2
`define UADM_PARITY_DATA_SELECT_9N       2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UADM_RST_BAUD       16'h0000
`define UADM_RST_ADMD       16'h0000
`define UADM_RST_RX_CHAR    9'h000
`define UADM_RST_CTRL       6'h00

// ----------------------------------------------------------------
// Bit timing in baud generator ticks, and last data bit index per format
// ----------------------------------------------------------------
`define UADM_LAST_HS        5'h03
`define UADM_LAST_STD       5'h0F
`define UADM_MID_HS         5'h01
`define UADM_MID_STD        5'h07
`define UADM_LAST_BIT_8     4'h7
`define UADM_LAST_BIT_9     4'h8

`endif

// File: uadm_peer.sv
`default_nettype none

module uadm_peer (
	input  wire logic        clock,
	input  wire logic        lineIn,
	output var  logic        lineOut,
	input  wire logic [20:0] bitLen,
	input  wire logic        nine
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] rxq[$];
	logic [8:0] c;
	initial lineOut = 1'b1;
	// Start, LSB first data, stop; 8-bit frames pad with idle
	task automatic send(input logic [8:0] ch);
		logic [10:0] f;
		f = {1'b1, nine ? ch : {1'b1, ch[7:0]}, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge clock);
			lineOut <= f[i];
			repeat (bitLen - 21'h1) @(posedge clock);
		end
	endtask
	// Receive at the middle of each bit
	always begin
		@(posedge clock iff lineIn === 1'b0);
		repeat (bitLen / 21'h2) @(posedge clock);
		c = 9'h000;
		for (int i = 0; i < (nine ? 9 : 8); i++) begin
			repeat (bitLen) @(posedge clock);
			c[i] = lineIn;
		end
		repeat (bitLen) @(posedge clock);
		rxq.push_back(c);
	end
endmodule // uadm_peer

`default_nettype wire

// File: uadm_pkg.sv
`default_nettype none

package uadm_pkg;
	typedef logic [31:0] uadm_word_type;
	typedef logic [8:0]  uadm_char_type;
	typedef logic [5:0]  uadm_addr_type;
	typedef enum logic [2:0] {
		UADM_IDLE,
		UADM_START,
		UADM_DATA,
		UADM_PARITY,
		UADM_STOP
	} uadm_line_state_type;
endpackage

`default_nettype wire

// File: uadm_props.sv
`default_nettype none

module uadm_props (
	input  wire logic                    clock,
	input  wire logic                    arst_n,
	input  wire uadm_pkg::uadm_addr_type avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire uadm_pkg::uadm_word_type avs_writedata,
	input  wire logic [3:0]              avs_byteenable,
	input  wire uadm_pkg::uadm_word_type avs_readdata,
	input  wire logic                    avs_waitrequest,
	input  wire logic                    serialIn,
	input  wire logic                    serialOut
);
	import uadm_pkg::*;
	logic [15:0] baud;
	logic [15:0] admd;
	logic [5:0]  ctrl;
	logic [20:0] run;
	logic [20:0] minLen;
	logic        prevOut;
	logic        rdDone;
	logic        wrDone;
	assign rdDone = avs_read && !avs_waitrequest;
	assign wrDone = avs_write && !avs_waitrequest;
	// Shortest legal level: one bit, less one tick for the start bit
	assign minLen = (ctrl[2] ? 21'h3 : 21'hF) * {5'h0, baud + 16'h1};
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			baud <= 16'h0000;
			admd <= 16'h0000;
			ctrl <= 6'h00;
			run <= 21'h1FFFFF;
			prevOut <= 1'b1;
		end else begin
			if (wrDone && avs_address == 6'h08)
				baud <= avs_writedata[15:0];
			if (wrDone && avs_address == 6'h0C)
				admd <= avs_writedata[15:0];
			if (wrDone && avs_address == 6'h10)
				ctrl <= avs_writedata[5:0];
			prevOut <= serialOut;
			if (serialOut != prevOut)
				run <= 21'h1;
			else if (run != 21'h1FFFFF)
				run <= run + 21'h1;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	// ----------------------------------------------------------------
	// Bus, register and serial bit length checks
	// ----------------------------------------------------------------
	a_rd_first_wait: assert property (avs_read && !$past(avs_read)
		|-> avs_waitrequest) else $error("read answered at once");
	a_rd_one_wait: assert property (avs_read && avs_waitrequest ##1 avs_read
		|-> !avs_waitrequest) else $error("read waited too long");
	a_wr_no_wait: assert property (avs_write && avs_address != 6'h04
		|-> !avs_waitrequest) else $error("register write stalled");
	a_unmapped_zero: assert property (
		rdDone && (avs_address == 6'h04 || avs_address > 6'h14)
		|-> avs_readdata == 32'h0) else $error("empty offset not zero");
	a_rx_upper_zero: assert property (
		rdDone && avs_address == 6'h00 |-> avs_readdata[31:9] == 23'h0)
		else $error("rx upper bits set");
	a_baud_readback: assert property (
		rdDone && avs_address == 6'h08 |-> avs_readdata == {16'h0, baud})
		else $error("divisor readback wrong");
	a_admd_readback: assert property (
		rdDone && avs_address == 6'h0C |-> avs_readdata == {16'h0, admd})
		else $error("match register readback wrong");
	a_bit_min_len: assert property (
		serialOut != prevOut |-> run >= minLen)
		else $error("serial bit too short");
	c_rx_read: cover property (rdDone && avs_address == 6'h00);
	c_tx_stall: cover property (avs_write && avs_waitrequest);
	c_tx_start: cover property ($fell(serialOut));
endmodule // uadm_props

`default_nettype wire

// File: uadm_serial_core.sv
`include "uadm_map.svh"
`default_nettype none
// Operation
// (RQ1) Received character shows in the low 9 bits, upper bits zero, reset 0.
// (RQ2) Software writes a 9-bit character to send; it reads back as zero.
// (RQ3) A 16-bit read/write divisor, reset 0, sets the baud generator rate.
// (RQ4) Only match-address bits whose mask bit is one take part in a match.
// (RQ5) In address detect mode hardware recognises the station address.
// (RQ6) Ninth bit one marks an address; detect mode needs 9-bit format.
// (RQ7) A bit lasts 4 generator ticks in high speed, 16 in standard speed.
// (RQ8) Parity/data select 11 means 9 data bits, no parity, bit 8 on top.
// (RQ9) Unaddressed data is dropped until a matching address passes it on.

module uadm_serial_core #(
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic                    clock,
	input  wire logic                    arst_n,
	input  wire uadm_pkg::uadm_addr_type avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire uadm_pkg::uadm_word_type avs_writedata,
	input  wire logic [3:0]              avs_byteenable,
	output var  uadm_pkg::uadm_word_type avs_readdata,
	output var  logic                    avs_waitrequest,
	input  wire logic                    serialIn,
	output var  logic                    serialOut
);
	import uadm_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                       ack;
		uadm_word_type              rdata;
		logic [15:0]                baud;
		logic [15:0]                admd;
		logic [`UADM_CTRL_W-1:0]    ctrl;
		logic [15:0]                baudCount;
		uadm_line_state_type        txState;
		logic [4:0]                 txTick;
		logic [3:0]                 txBit;
		uadm_char_type              txShift;
		logic                       txLow;
		uadm_line_state_type        rxState;
		logic [4:0]                 rxTick;
		logic [3:0]                 rxBit;
		uadm_char_type              rxShift;
		logic                       rxPar;
		uadm_char_type              rxChar;
		logic                       rxAvail;
		logic                       overrun;
		logic                       frameErr;
		logic                       parityErr;
		logic                       matched;
	} uadm_core_state_type;

	uadm_core_state_type cur;
	uadm_core_state_type next_cur;

	uadm_stream_if #(.WIDTH(9)) pushLink();
	uadm_stream_if #(.WIDTH(9)) popLink();

	logic [1:0] parity_data_select;
	logic       nineBit;
	logic       parityOn;
	logic       addrMode;
	logic       txEn;
	logic       rxEn;
	logic       tick;
	logic [4:0] lastTick;
	logic [4:0] midTick;
	logic [3:0] lastBit;
	logic       txSel;
	logic       busRead;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic parityOf(input uadm_char_type c,
		input logic [1:0] sel);
		return (sel == `UADM_PARITY_DATA_SELECT_8O) ? ~(^c[7:0]) : ^c[7:0];
	endfunction

	function automatic logic addrHit(input uadm_char_type c,
		input logic [15:0] admd);
		logic [7:0] mask;
		logic [7:0] addr;
		mask = admd[`UADM_MASK_LSB +: 8];
		addr = admd[`UADM_ADDR_LSB +: 8];
		return (((c[7:0] ^ addr) & mask) == 8'h00);
	endfunction

	function automatic logic [15:0] mergeHalf(input logic [15:0] old,
		input uadm_word_type wd, input logic [3:0] be);
		logic [15:0] res;
		res = old;
		if (be[0]) begin
			res[7:0] = wd[7:0];
		end
		if (be[1]) begin
			res[15:8] = wd[15:8];
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	assign parity_data_select    = cur.ctrl[`UADM_CTRL_PARITY_DATA_SELECT_LSB +: 2];
	assign nineBit  = (parity_data_select == `UADM_PARITY_DATA_SELECT_9N); // RQ8
	assign parityOn = (parity_data_select == `UADM_PARITY_DATA_SELECT_8E) || (parity_data_select == `UADM_PARITY_DATA_SELECT_8O);
	assign addrMode = cur.ctrl[`UADM_CTRL_ADDRESS_DETECT_ENABLE] && nineBit; // RQ6
	assign txEn     = cur.ctrl[`UADM_CTRL_TXEN];
	assign rxEn     = cur.ctrl[`UADM_CTRL_RXEN];
	// Compare by >= so a lowered divisor cannot stall the ticks
	assign tick     = (cur.baudCount >= cur.baud); // RQ3
	assign lastTick = cur.ctrl[`UADM_CTRL_HIGH_SPEED_BIT_TIMING] ? `UADM_LAST_HS
		: `UADM_LAST_STD; // RQ7
	assign midTick  = cur.ctrl[`UADM_CTRL_HIGH_SPEED_BIT_TIMING] ? `UADM_MID_HS
		: `UADM_MID_STD;
	assign lastBit  = nineBit ? `UADM_LAST_BIT_9 : `UADM_LAST_BIT_8;
	assign txSel    = (avs_address == `UADM_OFS_TX_CHAR);
	assign busRead  = avs_read && !cur.ack;

	// ----------------------------------------------------------------
	// Transmit buffer and bus handshake
	// ----------------------------------------------------------------
	assign pushLink.valid  = avs_write && txSel; // RQ2
	assign pushLink.data   = avs_writedata[8:0];
	assign popLink.ready   = txEn && (cur.txState == UADM_IDLE);
	assign avs_waitrequest = busRead
		|| (avs_write && txSel && !pushLink.ready);
	assign avs_readdata    = cur.rdata;
	assign serialOut       = ~cur.txLow;

	uadm_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) txBuffer (
		.clock  (clock),
		.arst_n (arst_n),
		.inPort (pushLink),
		.outPort(popLink)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_cur = cur;

		// Register reads take one wait cycle
		next_cur.ack = busRead;
		if (busRead) begin
			next_cur.rdata = '0;
			unique case (avs_address)
				`UADM_OFS_RX_CHAR: next_cur.rdata[8:0] = cur.rxChar; // RQ1
				`UADM_OFS_BAUD:    next_cur.rdata[15:0] = cur.baud;
				`UADM_OFS_ADMD:    next_cur.rdata[15:0] = cur.admd;
				`UADM_OFS_CTRL:
					next_cur.rdata[`UADM_CTRL_W-1:0] = cur.ctrl;
				`UADM_OFS_STAT: begin
					next_cur.rdata[`UADM_STAT_RXDA]    = cur.rxAvail;
					next_cur.rdata[`UADM_STAT_OERR]    = cur.overrun;
					next_cur.rdata[`UADM_STAT_FERR]    = cur.frameErr;
					next_cur.rdata[`UADM_STAT_PERR]    = cur.parityErr;
					next_cur.rdata[`UADM_STAT_RIDLE]   =
						(cur.rxState == UADM_IDLE);
					next_cur.rdata[`UADM_STAT_TRMT]    =
						(cur.txState == UADM_IDLE) && !popLink.valid;
					next_cur.rdata[`UADM_STAT_TXBF]    = !pushLink.ready;
					next_cur.rdata[`UADM_STAT_MATCHED] = cur.matched;
				end
				default: next_cur.rdata = '0;
			endcase
		end

		// Reading the received character consumes it
		if (avs_read && cur.ack && (avs_address == `UADM_OFS_RX_CHAR)) begin
			next_cur.rxAvail = 1'b0;
		end

		// Register writes; writing 0 to the overrun bit clears it
		if (avs_write) begin
			unique case (avs_address)
				`UADM_OFS_BAUD:
					next_cur.baud = mergeHalf(cur.baud, avs_writedata,
						avs_byteenable); // RQ3
				`UADM_OFS_ADMD:
					next_cur.admd = mergeHalf(cur.admd, avs_writedata,
						avs_byteenable);
				`UADM_OFS_CTRL: begin
					if (avs_byteenable[0]) begin
						next_cur.ctrl = avs_writedata[`UADM_CTRL_W-1:0];
					end
				end
				`UADM_OFS_STAT: begin
					if (avs_byteenable[0]
						&& !avs_writedata[`UADM_STAT_OERR]) begin
						next_cur.overrun = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// Baud generator: one tick every divisor + 1 clocks
		next_cur.baudCount = tick ? 16'h0000 : cur.baudCount + 16'h0001; // RQ3

		// Transmitter
		if (!txEn) begin
			next_cur.txState = UADM_IDLE;
			next_cur.txLow   = 1'b0;
		end else begin
			unique case (cur.txState)
				UADM_IDLE: begin
					if (popLink.valid) begin
						next_cur.txShift = popLink.data;
						next_cur.txState = UADM_START;
						next_cur.txTick  = 5'h00;
						next_cur.txLow   = 1'b1;
					end
				end
				UADM_START, UADM_DATA, UADM_PARITY, UADM_STOP: begin
					if (tick && (cur.txTick != lastTick)) begin
						next_cur.txTick = cur.txTick + 5'h01;
					end else if (tick) begin
						next_cur.txTick = 5'h00; // RQ7
						if (cur.txState == UADM_START) begin
							next_cur.txState = UADM_DATA;
							next_cur.txBit   = 4'h0;
							next_cur.txLow   = ~cur.txShift[0];
						end else if (cur.txState == UADM_DATA
							&& cur.txBit != lastBit) begin
							next_cur.txBit = cur.txBit + 4'h1;
							next_cur.txLow = ~cur.txShift[cur.txBit + 4'h1]; // RQ8
						end else if (cur.txState == UADM_DATA && parityOn) begin
							next_cur.txState = UADM_PARITY;
							next_cur.txLow   = ~parityOf(cur.txShift, parity_data_select);
						end else if (cur.txState != UADM_STOP) begin
							next_cur.txState = UADM_STOP;
							next_cur.txLow   = 1'b0;
						end else begin
							next_cur.txState = UADM_IDLE;
						end
					end
				end
				default: begin
					next_cur.txState = UADM_IDLE;
					next_cur.txLow   = 1'b0;
				end
			endcase
		end

		// Receiver
		if (!rxEn) begin
			next_cur.rxState = UADM_IDLE;
		end else begin
			unique case (cur.rxState)
				UADM_IDLE: begin
					if (tick && !serialIn) begin
						next_cur.rxState = UADM_START;
						next_cur.rxTick  = 5'h00;
						next_cur.rxShift = 9'h000;
					end
				end
				UADM_START, UADM_DATA, UADM_PARITY, UADM_STOP: begin
					if (tick) begin
						next_cur.rxTick = (cur.rxTick == lastTick) ? 5'h00
							: cur.rxTick + 5'h01; // RQ7
						if (cur.rxTick == midTick) begin
							if (cur.rxState == UADM_START && serialIn) begin
								next_cur.rxState = UADM_IDLE;
							end else if (cur.rxState == UADM_DATA) begin
								next_cur.rxShift[cur.rxBit] = serialIn; // RQ8
							end else if (cur.rxState == UADM_PARITY) begin
								next_cur.rxPar = serialIn;
							end else if (cur.rxState == UADM_STOP) begin
								next_cur.rxState = UADM_IDLE;
								// Address characters steer the pass gate
								if (addrMode && cur.rxShift[8]) begin // RQ6
									next_cur.matched =
										addrHit(cur.rxShift, cur.admd); // RQ4 RQ5 RQ9
								end
								if (!addrMode || next_cur.matched) begin // RQ9
									if (next_cur.rxAvail) begin
										next_cur.overrun = 1'b1;
									end else begin
										next_cur.rxChar    = cur.rxShift; // RQ1
										next_cur.rxAvail   = 1'b1;
										next_cur.frameErr  = !serialIn;
										next_cur.parityErr = parityOn
											&& (cur.rxPar
											!= parityOf(cur.rxShift, parity_data_select));
									end
								end
							end
						end else if (cur.rxTick == lastTick) begin
							if (cur.rxState == UADM_START) begin
								next_cur.rxState = UADM_DATA;
								next_cur.rxBit   = 4'h0;
							end else if (cur.rxState == UADM_DATA
								&& cur.rxBit != lastBit) begin
								next_cur.rxBit = cur.rxBit + 4'h1;
							end else if (cur.rxState == UADM_DATA) begin
								next_cur.rxState = parityOn ? UADM_PARITY
									: UADM_STOP;
							end else if (cur.rxState == UADM_PARITY) begin
								next_cur.rxState = UADM_STOP;
							end
						end
					end
				end
				default: next_cur.rxState = UADM_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cur <= '0; // RQ1 RQ3
		end else begin
			cur <= next_cur;
		end
	end
endmodule // uadm_serial_core

`default_nettype wire

// File: uadm_stream_if.sv
`default_nettype none

interface uadm_stream_if #(parameter int WIDTH = 9);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport producer(output valid, output data, input ready);
	modport consumer(input valid, input data, output ready);
endinterface

`default_nettype wire

// File: uart_data_baud_addr_match_bench.sv
`default_nettype none

bind uadm_serial_core uadm_props uadm_props_i (
	.clock(clock), .arst_n(arst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.serialIn(serialIn), .serialOut(serialOut));

module uart_data_baud_addr_match_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import uadm_pkg::*;
	logic          clock = 1'b0;
	logic          arst_n = 1'b0;
	logic          rd = 1'b0;
	logic          wr = 1'b0;
	logic          serialIn;
	logic          serialOut;
	logic          wt;
	logic          matched = 1'b0;
	logic          nine = 1'b1;
	logic [20:0]   bitLen = 21'h10;
	logic [15:0]   seed = 16'h0025;
	logic [8:0]    txq[$];
	logic [14:0]   tbl[10] = '{{6'h3B, 9'h033}, {6'h3B, 9'h1A3},
		{6'h3B, 9'h044}, {6'h3B, 9'h15C}, {6'h3B, 9'h077},
		{6'h3B, 9'h1FF}, {6'h3B, 9'h012}, {6'h33, 9'h0AB},
		{6'h33, 9'h1FF}, {6'h38, 9'h0C3}};
	uadm_addr_type offs[6] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h18, 6'h3C};
	uadm_addr_type addr = 6'h00;
	uadm_word_type wdata = 32'h0;
	uadm_word_type rdata;
	int            err_count = 0;
	int            tests_run = 0;
	int            waits = 0;
	always #20 clock = ~clock;
	uadm_serial_core uadm_serial_core_i (.clock(clock), .arst_n(arst_n),
		.avs_address(addr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdata), .avs_byteenable(4'h3),
		.avs_readdata(rdata), .avs_waitrequest(wt),
		.serialIn(serialIn), .serialOut(serialOut));
	uadm_peer uadm_peer_i (.clock(clock), .lineIn(serialOut),
		.lineOut(serialIn), .bitLen(bitLen), .nine(nine));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input uadm_word_type got, input uadm_word_type exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input uadm_addr_type a,
		input uadm_word_type d, output uadm_word_type q);
		int n;
		n = 0;
		@(posedge clock);
		addr <= a;
		wdata <= d;
		rd <= !w;
		wr <= w;
		do begin
			@(posedge clock);
			n++;
			if (n > 4000) begin
				err_count++;
				print_verdict();
			end
		end while (wt !== 1'b0);
		waits += n - 1;
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic put(input uadm_addr_type a, input uadm_word_type d);
		uadm_word_type q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdchk(input uadm_addr_type a, input uadm_word_type e);
		uadm_word_type q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic drain_tx;
		int n;
		n = 0;
		while (uadm_peer_i.rxq.size() < txq.size()) begin
			@(posedge clock);
			n++;
			if (n > 20000) begin
				err_count++;
				print_verdict();
			end
		end
		while (txq.size() > 0)
			chk({23'h0, uadm_peer_i.rxq.pop_front()}, {23'h0, txq.pop_front()});
	endtask
	task automatic rx_one(input logic [5:0] c, input logic [8:0] ch);
		logic detect;
		logic st;
		uadm_word_type q;
		detect = c[3] && c[1:0] == 2'h3;
		if (detect && ch[8])
			matched = ((ch[7:0] ^ 8'h5A) & 8'hF0) == 8'h00;
		st = !detect || matched;
		nine = c[1:0] == 2'h3;
		uadm_peer_i.send(ch);
		repeat (4) @(posedge clock);
		bus(1'b0, 6'h14, 32'h0, q);
		chk({31'h0, q[0]}, {31'h0, st});
		if (st)
			rdchk(6'h00, {23'h0, nine ? ch : {1'b0, ch[7:0]}});
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clock);
		arst_n <= 1'b1;
		foreach (offs[i])
			rdchk(offs[i], 32'h0);
		seed = lfsr(seed);
		put(6'h08, {seed, seed});
		rdchk(6'h08, {16'h0, seed});
		seed = lfsr(seed);
		put(6'h0C, {seed, seed});
		rdchk(6'h0C, {16'h0, seed});
		put(6'h08, 32'h0);
		put(6'h0C, 32'h0000F05A);
		put(6'h10, 32'h00000033);
		waits = 0;
		for (int i = 0; i < 10; i++) begin
			seed = lfsr(seed);
			txq.push_back(seed[8:0]);
			put(6'h04, {23'h0, seed[8:0]});
		end
		chk({31'h0, waits != 0}, 32'h1);
		drain_tx();
		put(6'h08, 32'h2);
		put(6'h10, 32'h00000037);
		bitLen = 21'h0C;
		txq.push_back(9'h0A5);
		put(6'h04, 32'h000000A5);
		drain_tx();
		rx_one(6'h37, 9'h155);
		put(6'h08, 32'h0);
		bitLen = 21'h10;
		foreach (tbl[i]) begin
			put(6'h10, {26'h0, tbl[i][14:9]});
			rx_one(tbl[i][14:9], tbl[i][8:0]);
		end
		// 8-bit format sends only the low eight bits
		txq.push_back(9'h03C);
		put(6'h04, 32'h0000013C);
		drain_tx();
		print_verdict();
	end
endmodule // uart_data_baud_addr_match_bench

`default_nettype wire
